// [bench/tb_lcialu_core.sv]
// Self-checking bench for the logic, compare and increment datapath slice.
// Assumes lcialu_pkg, lcialu_defs.svh and lcialu_core are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "lcialu_defs.svh"

module tb_lcialu_core;

	// ********************************************************
	// Signals
	// ********************************************************
	logic                    clk_i;
	logic                    reset_n_i;
	logic                    run_i;
	logic [7:0]              mem_rdata_i;
	logic [3:0]              reg_addr_i;
	logic [7:0]              reg_wdata_i;
	logic                    reg_wr_i;
	logic                    reg_rd_i;
	lcialu_pkg::lcialu_mem_s mem_o;
	logic [7:0]              reg_rdata_o;
	logic                    done_o;
	logic                    busy_o;
	logic [7:0]              mem [0:65535];
	int                      errors;
	int                      cmp_count;
	int                      cyc;
	logic [7:0]              a_tab [0:7] = '{8'h12, 8'h96, 8'h63, 8'h80, 8'h00, 8'h7F, 8'hA5, 8'h3C};
	logic [7:0]              s_tab [0:7] = '{8'h48, 8'h5D, 8'h60, 8'h01, 8'h00, 8'h7F, 8'hFF, 8'h0F};

	lcialu_core lcialu_core_i (
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.run_i       (run_i),
		.mem_rdata_i (mem_rdata_i),
		.reg_addr_i  (reg_addr_i),
		.reg_wdata_i (reg_wdata_i),
		.reg_wr_i    (reg_wr_i),
		.reg_rd_i    (reg_rd_i),
		.mem_o       (mem_o),
		.reg_rdata_o (reg_rdata_o),
		.done_o      (done_o),
		.busy_o      (busy_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ********************************************************
	// Memory and watchdog
	// ********************************************************
	always @(posedge clk_i) begin
		if (mem_o.wr)
			mem[mem_o.addr] <= mem_o.wdata;
		// Released bus alternates each cycle between the inverse of the last byte and the byte itself, so a stale sample is not held
		if (!reset_n_i)
			mem_rdata_i <= 8'h00;
		else
			mem_rdata_i <= mem_o.rd ? mem[mem_o.addr] : ~mem_rdata_i;
	end

	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			errors = errors + 1;
			close_out();
		end
	end

	// ********************************************************
	// Tasks
	// ********************************************************
	task automatic close_out();
		if (errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clk_i);
		reg_wr_i    <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clk_i);
		reg_rd_i   <= 1'b0;
		@(negedge clk_i);
		d = reg_rdata_o;
	endtask

	// Result in the upper byte, flags in the lower; bits 5 and 3 are carried over
	function automatic logic [15:0] model(input int kind, input logic [7:0] a,
			input logic [7:0] s, input logic [7:0] f);
		logic [8:0] d;
		logic [7:0] r;
		logic [7:0] g;
		d = {1'b0, a} - {1'b0, s};
		g = f & 8'h28;
		if (kind < 2) begin
			r = (kind == 0) ? (a | s) : (a ^ s);
			g[`LCIALU_FLAG_PV] = ~^r;
		end else if (kind == 2) begin
			r = d[7:0];
			g[`LCIALU_FLAG_H] = a[3:0] < s[3:0];
			g[`LCIALU_FLAG_PV] = (a[7] ^ s[7]) & (a[7] ^ r[7]);
			g[`LCIALU_FLAG_N] = 1'b1;
			g[`LCIALU_FLAG_C] = d[8];
		end else begin
			r = s + 8'h01;
			g[`LCIALU_FLAG_H] = s[3:0] == 4'hF;
			g[`LCIALU_FLAG_PV] = s == 8'h7F;
			g[`LCIALU_FLAG_C] = f[`LCIALU_FLAG_C];
		end
		g[`LCIALU_FLAG_S] = r[7];
		g[`LCIALU_FLAG_Z] = r == 8'h00;
		return {r, g};
	endfunction

	task automatic run_op(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
			input int nb, input logic [4:0] len);
		logic [7:0] v;
		int         n;
		wr(`LCIALU_ADR_PCL, 8'h00);
		wr(`LCIALU_ADR_PCH, 8'h01);
		mem[16'h0100] = b0;
		mem[16'h0101] = b1;
		mem[16'h0102] = b2;
		@(posedge clk_i);
		run_i <= 1'b1;
		@(posedge clk_i);
		run_i <= 1'b0;
		n = 0;
		@(negedge clk_i);
		while (mem_o.rd !== 1'b1 && n < 8) begin
			n++;
			@(negedge clk_i);
		end
		chk("busy", {7'h00, busy_o}, 8'h01);
		n = 0;
		while (done_o !== 1'b1 && n < 40) begin
			n++;
			@(negedge clk_i);
		end
		chk("t_states", n[7:0], {3'b000, len});
		rd(`LCIALU_ADR_PCL, v);
		chk("pc_low", v, nb[7:0]);
		rd(`LCIALU_ADR_STAT, v);
		chk("status", v, 8'h00);
	endtask

	// Form: 0 register, 1 immediate, 2 pointer, 3 first index, 4 second index
	task automatic alu_case(input int kind, input int form, input logic [2:0] r,
			input logic [7:0] a, input logic [7:0] s, input logic [7:0] f);
		logic [7:0]  op;
		logic [7:0]  pfx;
		logic [7:0]  v;
		logic [15:0] ea;
		logic [15:0] m;
		logic [2:0]  grp;
		logic [4:0]  len;
		int          i;
		grp = (kind == 0) ? `LCIALU_GRP_OR : (kind == 1) ? `LCIALU_GRP_XOR : `LCIALU_GRP_CMP;
		op = (kind == 3) ? {2'b00, (form == 0) ? r : `LCIALU_FLD_MEM, `LCIALU_FLD_INC}
			: {2'b10, grp, (form == 0) ? r : `LCIALU_FLD_MEM};
		if (form == 1)
			op = {2'b11, grp, 3'b110};
		pfx = (form == 4) ? `LCIALU_PFX_SECOND : `LCIALU_PFX_FIRST;
		for (i = 0; i < 6; i++) begin
			wr(i[3:0], 8'h81 + i[7:0]);
		end
		wr(`LCIALU_REG_FLAGS, f);
		wr(`LCIALU_REG_ACC, a);
		if (form == 0)
			wr({1'b0, r}, s);
		if (form == 0 && r == `LCIALU_REG_ACC)
			a = s;
		ea = 16'h2345;
		if (form == 2) begin
			wr(4'h4, 8'h23);
			wr(4'h5, 8'h45);
		end
		if (form >= 3) begin
			// Other index register points elsewhere; unsigned offset hits a decoy byte
			wr(`LCIALU_ADR_IXL, 8'h00);
			wr(`LCIALU_ADR_IXH, (form == 3) ? 8'h30 : 8'h50);
			wr(`LCIALU_ADR_IYL, 8'h00);
			wr(`LCIALU_ADR_IYH, (form == 4) ? 8'h30 : 8'h50);
			ea = 16'h2FF0;
			mem[16'h30F0] = ~s;
		end
		mem[ea] = s;
		len = (form == 0) ? `LCIALU_LEN_REG : (kind == 3) ? ((form == 2) ? `LCIALU_LEN_INC_M
			: `LCIALU_LEN_INC_X) : (form >= 3) ? `LCIALU_LEN_IDX : `LCIALU_LEN_MEM;
		if (form >= 3)
			run_op(pfx, op, 8'hF0, 3, len);
		else
			run_op(op, s, 8'h00, (form == 1) ? 2 : 1, len);
		m = model(kind, a, s, f);
		rd(`LCIALU_REG_FLAGS, v);
		if (kind == 2)
			chk("cmp_flags", v, m[7:0]);
		else if (kind == 3)
			chk("inc_flags", v, m[7:0]);
		else
			chk("logic_flags", v, m[7:0]);
		rd(`LCIALU_REG_ACC, v);
		chk("acc", v, (kind < 2 || (kind == 3 && form == 0 && r == 3'h7)) ? m[15:8] : a);
		if (kind == 3 && form == 0 && r != 3'h7) begin
			rd({1'b0, r}, v);
			chk("inc_reg", v, m[15:8]);
		end
		if (kind == 3 && form >= 2)
			chk("inc_mem", mem[ea], m[15:8]);
	endtask

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial begin
		int         i;
		int         k;
		int         r;
		int         f;
		int         j;
		logic [7:0] v;
		errors      = 0;
		cmp_count   = 0;
		reset_n_i   = 1'b0;
		run_i       = 1'b0;
		reg_addr_i  = 4'h0;
		reg_wdata_i = 8'h00;
		reg_wr_i    = 1'b0;
		reg_rd_i    = 1'b0;
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(negedge clk_i);
		chk("idle_busy", {7'h00, busy_o}, 8'h00);
		chk("idle_done", {7'h00, done_o}, 8'h00);
		for (i = 0; i < 16; i++) begin
			rd(i[3:0], v);
			chk("reset_reg", v, 8'h00);
		end
		wr(4'hF, 8'h5A);
		rd(4'hF, v);
		chk("spare_reg", v, 8'h00);
		wr(`LCIALU_ADR_STAT, 8'hFF);
		rd(`LCIALU_ADR_STAT, v);
		chk("status_ro", v, 8'h00);
		j = 0;
		for (k = 0; k < 4; k++) begin
			for (r = 0; r < 8; r++) begin
				if (r != 6) begin
					alu_case(k, 0, r[2:0], a_tab[j % 8], s_tab[j % 8], j[0] ? 8'hFF : 8'h00);
					j++;
				end
			end
		end
		for (k = 0; k < 3; k++) begin
			for (f = 1; f < 5; f++) begin
				alu_case(k, f, 3'h0, a_tab[j % 8], s_tab[j % 8], j[0] ? 8'hFF : 8'h00);
				j++;
			end
		end
		alu_case(3, 2, 3'h0, 8'h00, 8'h7F, 8'hFF);
		alu_case(3, 2, 3'h0, 8'h00, 8'h0F, 8'h00);
		alu_case(3, 3, 3'h0, 8'h00, 8'hFF, 8'h00);
		alu_case(3, 3, 3'h0, 8'h00, 8'h7F, 8'hFF);
		alu_case(2, 0, 3'h2, 8'h80, 8'h01, 8'h00);
		alu_case(2, 1, 3'h0, 8'h63, 8'h60, 8'hFF);
		close_out();
	end

endmodule // tb_lcialu_core
`default_nettype wire

// [common/lcialu_defs.svh]
// Constants of the logic, compare and increment datapath slice.
// Assumes one T state per rising edge of clk_i (100 MHz, 10 ns).
`ifndef LCIALU_DEFS_SVH
`define LCIALU_DEFS_SVH

// ********************************************************
// Opcodes and fields
// ********************************************************
`define LCIALU_OP_OR_N    8'hF6
`define LCIALU_OP_OR_M    8'hB6
`define LCIALU_OP_XOR_N   8'hEE
`define LCIALU_OP_XOR_M   8'hAE
`define LCIALU_OP_CMP_N   8'hFE
`define LCIALU_OP_CMP_M   8'hBE
`define LCIALU_OP_INC_M   8'h34
`define LCIALU_PFX_FIRST  8'hDD
`define LCIALU_PFX_SECOND 8'hFD
`define LCIALU_GRP_XOR    3'h5
`define LCIALU_GRP_OR     3'h6
`define LCIALU_GRP_CMP    3'h7
`define LCIALU_FLD_MEM    3'h6
`define LCIALU_FLD_INC    3'h4
`define LCIALU_REG_LAST   3'h5
`define LCIALU_REG_FLAGS  3'h6
`define LCIALU_REG_ACC    3'h7

// ********************************************************
// Flag bit positions
// ********************************************************
`define LCIALU_FLAG_S  7
`define LCIALU_FLAG_Z  6
`define LCIALU_FLAG_H  4
`define LCIALU_FLAG_PV 2
`define LCIALU_FLAG_N  1
`define LCIALU_FLAG_C  0

// ********************************************************
// Machine cycle lengths (last T state index) and totals
// ********************************************************
`define LCIALU_T_FETCH   3'h3
`define LCIALU_T_READ    3'h2
`define LCIALU_T_ADDR    3'h4
`define LCIALU_T_RMW_RD  3'h3
`define LCIALU_T_WRITE   3'h2
`define LCIALU_LEN_REG   5'h04
`define LCIALU_LEN_MEM   5'h07
`define LCIALU_LEN_IDX   5'h13
`define LCIALU_LEN_INC_M 5'h0B
`define LCIALU_LEN_INC_X 5'h17

// ********************************************************
// Register port map and reset values
// ********************************************************
`define LCIALU_ADR_IXL   4'h8
`define LCIALU_ADR_IXH   4'h9
`define LCIALU_ADR_IYL   4'hA
`define LCIALU_ADR_IYH   4'hB
`define LCIALU_ADR_PCL   4'hC
`define LCIALU_ADR_PCH   4'hD
`define LCIALU_ADR_STAT  4'hE
`define LCIALU_RST_BYTE  8'h00
`define LCIALU_RST_WORD  16'h0000

`endif

// [common/lcialu_pkg.sv]
// Types of the logic, compare and increment datapath slice.
// Assumes lcialu_defs.svh is compiled alongside.
package lcialu_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_DISP,
		ST_ADDR,
		ST_OPND,
		ST_RMW_RD,
		ST_RMW_WR
	} lcialu_state_e;

	typedef enum logic [1:0] {
		ALU_OR,
		ALU_XOR,
		ALU_CMP,
		ALU_INC
	} lcialu_aop_e;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} lcialu_mem_s;

	typedef struct packed {
		logic [7:0] result;
		logic [7:0] flags;
	} lcialu_alu_s;

	typedef struct packed {
		lcialu_state_e   st;
		logic [2:0]      t;
		logic [2:0]      last;
		logic [4:0]      len;
		logic [4:0]      done_len;
		logic            done;
		logic            busy;
		logic            idx_on;
		logic            idx_y;
		logic            was_idx;
		logic            imm;
		logic [7:0]      op;
		lcialu_aop_e     aop;
		logic [7:0]      opnd;
		logic [15:0]     ea;
		logic [15:0]     ix;
		logic [15:0]     iy;
		logic [15:0]     pc;
		logic [7:0][7:0] regs;
		logic [7:0]      rdata;
		lcialu_mem_s     mem;
	} lcialu_core_s;

endpackage

// [verilog/lcialu_alu.sv]
// Combinational flag and result unit for OR, XOR, compare and increment.
// Assumes the caller registers result and flags.
`timescale 1ns/1ps
`default_nettype none
`include "lcialu_defs.svh"

module lcialu_alu (
	input  wire lcialu_pkg::lcialu_aop_e op_i,
	input  wire logic [7:0]              a_i,
	input  wire logic [7:0]              b_i,
	input  wire logic [7:0]              flags_i,
	output var lcialu_pkg::lcialu_alu_s  out_o
);

	// Even number of ones, zero ones counting as even
	function automatic logic even_par(input logic [7:0] v);
		even_par = ~^v;
	endfunction

	logic [8:0] diff;
	logic [7:0] r;
	logic [7:0] f;

	always_comb begin
		diff = {1'b0, a_i} - {1'b0, b_i};
		r = a_i;
		f = flags_i;
		case (op_i)
			lcialu_pkg::ALU_OR: begin
				r = a_i | b_i;
				f[`LCIALU_FLAG_H] = 1'b0;
				f[`LCIALU_FLAG_N] = 1'b0;
				f[`LCIALU_FLAG_C] = 1'b0;
				f[`LCIALU_FLAG_PV] = even_par(r);
			end
			lcialu_pkg::ALU_XOR: begin
				r = a_i ^ b_i;
				f[`LCIALU_FLAG_H] = 1'b0;
				f[`LCIALU_FLAG_N] = 1'b0;
				f[`LCIALU_FLAG_C] = 1'b0;
				f[`LCIALU_FLAG_PV] = even_par(r);
			end
			lcialu_pkg::ALU_CMP: begin
				r = diff[7:0];
				f[`LCIALU_FLAG_H] = (a_i[3:0] < b_i[3:0]);
				f[`LCIALU_FLAG_N] = 1'b1;
				f[`LCIALU_FLAG_C] = diff[8];
				f[`LCIALU_FLAG_PV] = (a_i[7] ^ b_i[7]) & (a_i[7] ^ diff[7]);
			end
			default: begin
				r = a_i + 8'h01;
				// Carry is left as it was
				f[`LCIALU_FLAG_H] = (a_i[3:0] == 4'hF);
				f[`LCIALU_FLAG_N] = 1'b0;
				f[`LCIALU_FLAG_PV] = (a_i == 8'h7F);
			end
		endcase
		f[`LCIALU_FLAG_S] = r[7];
		f[`LCIALU_FLAG_Z] = (r == 8'h00);
		out_o.result = r;
		out_o.flags = f;
	end

endmodule // lcialu_alu

`default_nettype wire

// [verilog/lcialu_core.sv]
// Sequencer and register slice for OR, XOR, compare and increment.
// Assumes a synchronous byte memory that returns read data by the last
// T state of a read cycle, and one T state per rising clk_i edge.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lcialu_defs.svh"

// Summary of operation
// - Select field codes 000-101 pick six byte registers, 111 picks accumulator.
// - OR stores accumulator OR operand into accumulator; F6 immediate, B6 pointer.
// - OR and XOR clear H, N, C; P/V shows even parity.
// - XOR stores accumulator XOR operand into accumulator.
// - Operands: register, immediate, pointer byte, or index plus displacement byte.
// - Register form 4 T, immediate/pointer 7 T, indexed 19 T.
// - Compare subtracts for flags only; FE immediate, BE pointer.
// - Compare: H on borrow from bit 4, N set, P/V overflow, C borrow.
// - S follows result sign, Z set when result is zero.
// - Pattern 00 rrr 100 increments a register in 4 T states.
// - Increment: H on bit 3 carry, P/V if 7F before, N clear, C kept.
// - Opcode 34 increments the pointer-addressed byte in 11 T states.
// - Prefix DD or FD adds signed displacement to the chosen index register.
// - Indexed increment read-modify-write takes 23 T states.
module lcialu_core (
	input  wire logic                   clk_i,
	input  wire logic                   reset_n_i,
	input  wire logic                   run_i,
	input  wire logic [7:0]             mem_rdata_i,
	input  wire logic [3:0]             reg_addr_i,
	input  wire logic [7:0]             reg_wdata_i,
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	output var lcialu_pkg::lcialu_mem_s mem_o,
	output logic [7:0]                  reg_rdata_o,
	output logic                        done_o,
	output logic                        busy_o
);

	// ********************************************************
	// Decode helpers
	// ********************************************************
	function automatic logic is_alu(input logic [7:0] op);
		is_alu = op[7] && (op[5:3] >= `LCIALU_GRP_XOR)
			&& (!op[6] || op[2:0] == `LCIALU_FLD_MEM);
	endfunction

	function automatic lcialu_pkg::lcialu_aop_e dec_aop(input logic [7:0] op);
		if (!is_alu(op)) begin
			dec_aop = lcialu_pkg::ALU_INC;
		end else if (op[5:3] == `LCIALU_GRP_OR) begin
			dec_aop = lcialu_pkg::ALU_OR;
		end else if (op[5:3] == `LCIALU_GRP_XOR) begin
			dec_aop = lcialu_pkg::ALU_XOR;
		end else begin
			dec_aop = lcialu_pkg::ALU_CMP;
		end
	endfunction

	function automatic lcialu_pkg::lcialu_core_s begin_mc(
		input lcialu_pkg::lcialu_core_s s,
		input lcialu_pkg::lcialu_state_e st,
		input logic [15:0]              a,
		input logic                     rd,
		input logic                     wr,
		input logic [2:0]               last
	);
		begin_mc = s;
		begin_mc.st = st;
		begin_mc.t = 3'h0;
		begin_mc.last = last;
		begin_mc.mem.addr = a;
		begin_mc.mem.rd = rd;
		begin_mc.mem.wr = wr;
	endfunction

	// ********************************************************
	// State
	// ********************************************************
	lcialu_pkg::lcialu_core_s cur;
	lcialu_pkg::lcialu_core_s nxt;
	lcialu_pkg::lcialu_alu_s  alu;
	lcialu_pkg::lcialu_aop_e  aop_now;
	logic [7:0]               op_now;
	logic [7:0]               src;
	logic [7:0]               alu_a;
	logic                     mc_end;
	logic [15:0]              hl;

	assign hl = {cur.regs[4], cur.regs[5]};
	assign mc_end = (cur.st != lcialu_pkg::ST_IDLE) && (cur.t == cur.last);

	// Operand steering: registers during the fetch, memory data afterwards
	always_comb begin
		op_now = (cur.st == lcialu_pkg::ST_FETCH) ? mem_rdata_i : cur.op;
		aop_now = (cur.st == lcialu_pkg::ST_FETCH) ? dec_aop(mem_rdata_i) : cur.aop;
		if (cur.st == lcialu_pkg::ST_FETCH) begin
			src = (aop_now == lcialu_pkg::ALU_INC) ?
				cur.regs[op_now[5:3]] : cur.regs[op_now[2:0]];
		end else begin
			src = mem_rdata_i;
		end
		alu_a = (aop_now == lcialu_pkg::ALU_INC) ? src : cur.regs[`LCIALU_REG_ACC];
	end

	lcialu_alu lcialu_alu_i (
		.op_i    (aop_now),
		.a_i     (alu_a),
		.b_i     (src),
		.flags_i (cur.regs[`LCIALU_REG_FLAGS]),
		.out_o   (alu)
	);

	// ********************************************************
	// Next state
	// ********************************************************
	always_comb begin
		nxt = cur;
		nxt.done = 1'b0;
		if (cur.st != lcialu_pkg::ST_IDLE) begin
			nxt.t = cur.t + 3'h1;
			nxt.len = cur.len + 5'h01;
		end

		// Register port; the sequencer below overrides a same-cycle write
		if (reg_rd_i) begin
			case (reg_addr_i)
				`LCIALU_ADR_IXL:  nxt.rdata = cur.ix[7:0];
				`LCIALU_ADR_IXH:  nxt.rdata = cur.ix[15:8];
				`LCIALU_ADR_IYL:  nxt.rdata = cur.iy[7:0];
				`LCIALU_ADR_IYH:  nxt.rdata = cur.iy[15:8];
				`LCIALU_ADR_PCL:  nxt.rdata = cur.pc[7:0];
				`LCIALU_ADR_PCH:  nxt.rdata = cur.pc[15:8];
				`LCIALU_ADR_STAT: nxt.rdata = {6'h00, cur.idx_on,
					(cur.st != lcialu_pkg::ST_IDLE)};
				default: begin
					if (reg_addr_i[3]) begin
						nxt.rdata = 8'h00;
					end else begin
						nxt.rdata = cur.regs[reg_addr_i[2:0]];
					end
				end
			endcase
		end
		if (reg_wr_i) begin
			case (reg_addr_i)
				`LCIALU_ADR_IXL: nxt.ix[7:0] = reg_wdata_i;
				`LCIALU_ADR_IXH: nxt.ix[15:8] = reg_wdata_i;
				`LCIALU_ADR_IYL: nxt.iy[7:0] = reg_wdata_i;
				`LCIALU_ADR_IYH: nxt.iy[15:8] = reg_wdata_i;
				`LCIALU_ADR_PCL: nxt.pc[7:0] = reg_wdata_i;
				`LCIALU_ADR_PCH: nxt.pc[15:8] = reg_wdata_i;
				default: begin
					if (!reg_addr_i[3]) begin
						nxt.regs[reg_addr_i[2:0]] = reg_wdata_i;
					end
				end
			endcase
		end

		case (cur.st)
			lcialu_pkg::ST_IDLE: begin
				if (run_i) begin
					nxt = begin_mc(nxt, lcialu_pkg::ST_FETCH, cur.pc, 1'b1, 1'b0,
						`LCIALU_T_FETCH);
					nxt.len = 5'h00;
				end
			end
			lcialu_pkg::ST_FETCH: begin
				if (mc_end) begin
					nxt.pc = cur.pc + 16'h0001;
					nxt.op = op_now;
					nxt.aop = aop_now;
					nxt.imm = op_now[6];
					if (!cur.idx_on && (op_now == `LCIALU_PFX_FIRST
						|| op_now == `LCIALU_PFX_SECOND)) begin
						// Prefix: a second opcode fetch follows
						nxt = begin_mc(nxt, lcialu_pkg::ST_FETCH, nxt.pc, 1'b1, 1'b0,
							`LCIALU_T_FETCH);
						nxt.idx_on = 1'b1;
						nxt.idx_y = (op_now == `LCIALU_PFX_SECOND);
					end else begin
						nxt.idx_on = 1'b0;
						nxt.was_idx = cur.idx_on;
						nxt.st = lcialu_pkg::ST_IDLE;
						if ((is_alu(op_now) || op_now == `LCIALU_OP_INC_M)
							&& op_now[2:0] == `LCIALU_FLD_MEM | op_now == `LCIALU_OP_INC_M) begin
							if (op_now[6]) begin
								nxt = begin_mc(nxt, lcialu_pkg::ST_OPND, nxt.pc, 1'b1, 1'b0,
									`LCIALU_T_READ);
							end else if (cur.idx_on) begin
								nxt = begin_mc(nxt, lcialu_pkg::ST_DISP, nxt.pc, 1'b1, 1'b0,
									`LCIALU_T_READ);
							end else if (op_now == `LCIALU_OP_INC_M) begin
								nxt = begin_mc(nxt, lcialu_pkg::ST_RMW_RD, hl, 1'b1, 1'b0,
									`LCIALU_T_RMW_RD);
								nxt.ea = hl;
							end else begin
								nxt = begin_mc(nxt, lcialu_pkg::ST_OPND, hl, 1'b1, 1'b0,
									`LCIALU_T_READ);
							end
						end else if (is_alu(op_now)) begin
							// Register form ends with its fetch
							if (aop_now != lcialu_pkg::ALU_CMP) begin
								nxt.regs[`LCIALU_REG_ACC] = alu.result;
							end
							nxt.regs[`LCIALU_REG_FLAGS] = alu.flags;
						end else if (op_now[7:6] == 2'h0 && op_now[2:0] == `LCIALU_FLD_INC) begin
							nxt.regs[op_now[5:3]] = alu.result;
							nxt.regs[`LCIALU_REG_FLAGS] = alu.flags;
						end
					end
				end
			end
			lcialu_pkg::ST_DISP: begin
				if (mc_end) begin
					nxt.pc = cur.pc + 16'h0001;
					nxt.ea = (cur.idx_y ? cur.iy : cur.ix)
						+ {{8{mem_rdata_i[7]}}, mem_rdata_i};
					nxt = begin_mc(nxt, lcialu_pkg::ST_ADDR, nxt.ea, 1'b0, 1'b0,
						`LCIALU_T_ADDR);
				end
			end
			lcialu_pkg::ST_ADDR: begin
				if (mc_end) begin
					if (cur.aop == lcialu_pkg::ALU_INC) begin
						nxt = begin_mc(nxt, lcialu_pkg::ST_RMW_RD, cur.ea, 1'b1, 1'b0,
							`LCIALU_T_RMW_RD);
					end else begin
						nxt = begin_mc(nxt, lcialu_pkg::ST_OPND, cur.ea, 1'b1, 1'b0,
							`LCIALU_T_READ);
					end
				end
			end
			lcialu_pkg::ST_OPND: begin
				if (mc_end) begin
					if (cur.imm) begin
						nxt.pc = cur.pc + 16'h0001;
					end
					if (cur.aop != lcialu_pkg::ALU_CMP) begin
						nxt.regs[`LCIALU_REG_ACC] = alu.result;
					end
					nxt.regs[`LCIALU_REG_FLAGS] = alu.flags;
					nxt.st = lcialu_pkg::ST_IDLE;
				end
			end
			lcialu_pkg::ST_RMW_RD: begin
				if (mc_end) begin
					nxt.opnd = alu.result;
					nxt.regs[`LCIALU_REG_FLAGS] = alu.flags;
					nxt = begin_mc(nxt, lcialu_pkg::ST_RMW_WR, cur.ea, 1'b0, 1'b1,
						`LCIALU_T_WRITE);
					nxt.mem.wdata = alu.result;
				end
			end
			lcialu_pkg::ST_RMW_WR: begin
				if (mc_end) begin
					nxt.st = lcialu_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt.st = lcialu_pkg::ST_IDLE;
			end
		endcase

		// Instruction end: chain the next fetch at once so no T state is lost
		if (mc_end && nxt.st == lcialu_pkg::ST_IDLE) begin
			nxt.done = 1'b1;
			nxt.done_len = cur.len + 5'h01;
			nxt.mem.rd = 1'b0;
			nxt.mem.wr = 1'b0;
			if (run_i) begin
				nxt = begin_mc(nxt, lcialu_pkg::ST_FETCH, nxt.pc, 1'b1, 1'b0,
					`LCIALU_T_FETCH);
				nxt.len = 5'h00;
			end
		end
		// Registered so busy_o leaves straight from a flop
		nxt.busy = (nxt.st != lcialu_pkg::ST_IDLE);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cur <= '0;
		end else begin
			cur <= nxt;
		end
	end

	assign mem_o = cur.mem;
	assign reg_rdata_o = cur.rdata;
	assign done_o = cur.done;
	assign busy_o = cur.busy;

	// ********************************************************
	// Checks
	// ********************************************************
	logic alu_done;
	assign alu_done = cur.done && is_alu(cur.op);

	reg_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		alu_done && !cur.op[6] && cur.op[2:0] != `LCIALU_FLD_MEM
			|-> cur.done_len == `LCIALU_LEN_REG)
		else $error("register form length wrong");

	idx_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		alu_done && cur.was_idx && !cur.op[6] |-> cur.done_len == `LCIALU_LEN_IDX)
		else $error("indexed form length wrong");

	inc_ptr_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		cur.done && cur.op == `LCIALU_OP_INC_M && !cur.was_idx
			|-> cur.done_len == `LCIALU_LEN_INC_M)
		else $error("pointer increment length wrong");

	inc_idx_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		cur.done && cur.op == `LCIALU_OP_INC_M && cur.was_idx
			|-> cur.done_len == `LCIALU_LEN_INC_X)
		else $error("indexed increment length wrong");

	logic_flags_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		alu_done && cur.op[5:3] != `LCIALU_GRP_CMP
			|-> cur.regs[6][`LCIALU_FLAG_H] == 1'b0 && cur.regs[6][`LCIALU_FLAG_C] == 1'b0
			&& cur.regs[6][`LCIALU_FLAG_PV] == ~^cur.regs[7]
			&& cur.regs[6][`LCIALU_FLAG_Z] == (cur.regs[7] == 8'h00))
		else $error("logic flags wrong");

	cmp_keeps_acc_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		alu_done && cur.op[5:3] == `LCIALU_GRP_CMP
			|-> cur.regs[7] == $past(cur.regs[7]) && cur.regs[6][`LCIALU_FLAG_N])
		else $error("compare altered accumulator");

	inc_acc_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		cur.done && cur.op == 8'h3C && !$past(reg_wr_i)
			|-> cur.regs[7] == $past(cur.regs[7]) + 8'h01
			&& cur.regs[6][`LCIALU_FLAG_C] == $past(cur.regs[6][`LCIALU_FLAG_C]))
		else $error("register increment wrong");

	rmw_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		cur.st == lcialu_pkg::ST_RMW_RD && mc_end
			|=> (mem_o.wr && mem_o.addr == $past(cur.ea)
			&& mem_o.wdata == $past(mem_rdata_i) + 8'h01) ##3 (done_o && !mem_o.wr))
		else $error("write-back wrong");

endmodule // lcialu_core

`default_nettype wire
